//--- rtl/quad_cfg.svh
`ifndef QUAD_CFG_SVH
`define QUAD_CFG_SVH

`define QP_LINES      32'd1024
`define QP_POS_W      32
`define QP_TURN_W     16
`define QP_CLK_MHZ    250
`define QP_STEP_NS    100
`define QP_STEP_CYC   ((`QP_STEP_NS * `QP_CLK_MHZ + 999) / 1000)
`define QP_STEP_CNT_W 8

`endif

//--- rtl/quad_counter.sv
// Function
// R01: encoder gives fixed, evenly spaced pulses per turn
// R02: two tracks, equal period, quarter-period offset
// R03: single track allowed without direction sensing
// R04: direction from which track leads
// R05: one edge of one track: N counts
// R06: both edges one track or one edge both: 2N
// R07: all edges of both tracks: 4N counts
// R08: count only after home-seeking pass completes
// R09: power loss or corruption forces re-initialization
// R10: optional marker pulse at zero position
// R11: two-stage synchronizers; flag simultaneous track change
// R12: first marker loads zero, then sets valid
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg.svh"

module quad_counter
    import quad_pkg::*;
(
    input  wire logic                   REF_CLK_IN,
    input  wire logic                   RST_IN,
    input  wire logic [1:0]             MODE_IN,
    input  wire logic                   SINGLE_IN,
    input  wire logic                   INIT_IN,
    output logic      [`QP_POS_W-1:0]   POSITION_OUT,
    output logic      [`QP_TURN_W-1:0]  TURNS_OUT,
    output logic                        VALID_OUT,
    output logic                        SEEKING_OUT,
    output logic                        DIR_OUT,
    output logic                        ERROR_OUT,
    quad_if.counter                     link
);

    // counts in one turn for the chosen edge selection
    function automatic logic [`QP_POS_W-1:0] turn_counts(input logic [1:0] mode);
        logic [`QP_POS_W-1:0] n;
        n = `QP_LINES;
        unique case (mode)
            MODE_X1: turn_counts = n; // R05
            MODE_X2: turn_counts = n << 1; // R06
            MODE_X4: turn_counts = n << 2; // R07
            default: turn_counts = n;
        endcase
    endfunction

    logic [2:0]           raw;
    logic [2:0]           meta_q;
    logic [2:0]           sync_q;
    logic [2:0]           prev_q;
    logic                 a;
    logic                 b;
    logic                 z;
    logic                 a_edge;
    logic                 b_edge;
    logic                 z_rise;
    logic                 both_edge;
    logic                 count_en;
    logic                 fwd;
    logic                 fwd_q;
    logic [`QP_POS_W-1:0] span;
    logic [`QP_POS_W-1:0] pos_q;
    logic [`QP_POS_W-1:0] pos_d;
    logic [`QP_TURN_W-1:0] turns_q;
    logic [`QP_TURN_W-1:0] turns_d;
    logic                 error_q;
    init_state_e          state_q;
    init_state_e          state_d;

    assign raw = {link.marker, link.track_b, link.track_a};

    // pins are asynchronous to our clock, two flops before any use
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                    prev_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= raw[g]; // R11
                    sync_q[g] <= meta_q[g]; // R11
                    prev_q[g] <= sync_q[g];
                end
            end
        end
    endgenerate

    assign a         = sync_q[0];
    assign b         = sync_q[1];
    assign z         = sync_q[2];
    assign a_edge    = a ^ prev_q[0];
    assign b_edge    = b ^ prev_q[1];
    assign z_rise    = z && !prev_q[2];
    assign both_edge = a_edge && b_edge; // R11
    assign span      = turn_counts(MODE_IN);

    // a leading b means forward; a single track has no direction
    always_comb begin
        fwd      = fwd_q;
        count_en = 1'b0;
        if (both_edge) begin
            count_en = 1'b0;
        end else if (a_edge) begin
            fwd = SINGLE_IN ? 1'b1 : (a != b); // R04
            unique case (MODE_IN)
                MODE_X1: count_en = SINGLE_IN ? a : (a == fwd); // R05
                MODE_X2: count_en = 1'b1; // R06
                MODE_X4: count_en = 1'b1; // R07
                default: count_en = 1'b0;
            endcase
        end else if (b_edge && !SINGLE_IN) begin
            fwd      = (a == b); // R04
            count_en = (MODE_IN == MODE_X4); // R07
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            fwd_q <= 1'b1;
        end else begin
            fwd_q <= fwd; // R04
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_UNINIT: begin
                if (INIT_IN && !both_edge) begin
                    state_d = ST_SEEK; // R08
                end
            end
            ST_SEEK: begin
                if (both_edge) begin
                    state_d = ST_UNINIT; // R09
                end else if (z_rise) begin
                    state_d = ST_VALID; // R12
                end
            end
            ST_VALID: begin
                if (both_edge) begin
                    state_d = ST_UNINIT; // R09
                end else if (INIT_IN) begin
                    state_d = ST_SEEK; // R09
                end
            end
            default: state_d = ST_UNINIT;
        endcase
    end

    // reset stands for power loss: position is never valid out of reset
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q <= ST_UNINIT; // R09
        end else begin
            state_q <= state_d;
        end
    end

    // wrap within one turn so the marker lands back on zero
    always_comb begin
        pos_d   = pos_q;
        turns_d = turns_q;
        if (state_q == ST_SEEK && z_rise) begin
            pos_d   = '0; // R12
            turns_d = '0; // R12
        end else if (state_q == ST_VALID && count_en && !both_edge) begin
            if (fwd) begin
                if (pos_q >= span - 1'b1) begin
                    pos_d   = '0; // R08
                    turns_d = turns_q + 1'b1;
                end else begin
                    pos_d = pos_q + 1'b1; // R08
                end
            end else begin
                if (pos_q == '0 || pos_q >= span) begin
                    pos_d   = span - 1'b1; // R08
                    turns_d = turns_q - 1'b1;
                end else begin
                    pos_d = pos_q - 1'b1; // R08
                end
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pos_q   <= '0;
            turns_q <= '0;
        end else begin
            pos_q   <= pos_d;
            turns_q <= turns_d;
        end
    end

    // a new collision wins over a clear by a fresh init request
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            error_q <= 1'b0;
        end else if (both_edge) begin
            error_q <= 1'b1; // R11
        end else if (INIT_IN) begin
            error_q <= 1'b0;
        end
    end

    // position is only shown once it is backed by a home reference
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            POSITION_OUT <= '0;
            TURNS_OUT    <= '0;
            VALID_OUT    <= 1'b0;
            SEEKING_OUT  <= 1'b0;
            DIR_OUT      <= 1'b1;
            ERROR_OUT    <= 1'b0;
        end else begin
            POSITION_OUT <= (state_d == ST_VALID) ? pos_d : '0; // R08
            TURNS_OUT    <= (state_d == ST_VALID) ? turns_d : '0;
            VALID_OUT    <= (state_d == ST_VALID); // R08 R12
            SEEKING_OUT  <= (state_d == ST_SEEK);
            DIR_OUT      <= fwd;
            ERROR_OUT    <= both_edge || (error_q && !INIT_IN);
        end
    end

endmodule

`default_nettype wire

//--- rtl/quad_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg.svh"

module quad_encoder
    import quad_pkg::*;
(
    input  wire logic        REF_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        RUN_IN,
    input  wire logic        DIR_IN,
    input  wire logic        SINGLE_IN,
    input  wire logic        MARKER_EN_IN,
    output logic      [31:0] ANGLE_OUT,
    quad_if.encoder          link
);

    localparam logic [`QP_STEP_CNT_W-1:0] STEP_LAST = (`QP_STEP_CNT_W)'(`QP_STEP_CYC - 1);
    localparam logic [31:0]               QSTEPS    = `QP_LINES * 32'd4;

    logic [`QP_STEP_CNT_W-1:0] tick_q;
    logic                      step;
    logic [31:0]               angle_q;
    logic [31:0]               angle_d;
    logic [1:0]                phase;

    assign step = RUN_IN && (tick_q == STEP_LAST);

    // fixed tick keeps every quarter step the same length
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tick_q <= '0;
        end else if (!RUN_IN || tick_q == STEP_LAST) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    always_comb begin
        angle_d = angle_q;
        if (step) begin
            if (DIR_IN) begin
                angle_d = (angle_q == 32'd0) ? QSTEPS - 32'd1 : angle_q - 32'd1; // R01
            end else begin
                angle_d = (angle_q == QSTEPS - 32'd1) ? 32'd0 : angle_q + 32'd1; // R01
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            angle_q <= '0;
        end else begin
            angle_q <= angle_d;
        end
    end

    assign phase = angle_d[1:0];

    // gray walk 00,10,11,01 puts b a quarter period behind a
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            link.track_a <= 1'b0;
            link.track_b <= 1'b0;
            link.marker  <= 1'b0;
            ANGLE_OUT    <= '0;
        end else begin
            link.track_a <= phase[1] ^ phase[0]; // R02
            link.track_b <= phase[1] && !SINGLE_IN; // R02 R03
            link.marker  <= MARKER_EN_IN && (angle_d == 32'd0); // R10
            ANGLE_OUT    <= angle_d;
        end
    end

endmodule

`default_nettype wire

//--- rtl/quad_if.sv
`timescale 1ns/1ps
`default_nettype none

interface quad_if;
    logic track_a;
    logic track_b;
    logic marker;

    modport encoder (
        output track_a,
        output track_b,
        output marker
    );

    modport counter (
        input  track_a,
        input  track_b,
        input  marker
    );
endinterface

`default_nettype wire

//--- rtl/quad_pkg.sv
`default_nettype none

package quad_pkg;

    typedef enum logic [1:0] {
        MODE_X1 = 2'b00,
        MODE_X2 = 2'b01,
        MODE_X4 = 2'b10
    } count_mode_e;

    typedef enum logic [1:0] {
        ST_UNINIT = 2'b00,
        ST_SEEK   = 2'b01,
        ST_VALID  = 2'b10
    } init_state_e;

endpackage

`default_nettype wire

//--- verif/quad_properties.sv
`timescale 1ns/1ps
`default_nettype none

module quad_properties (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic track_a,
    input wire logic track_b,
    input wire logic marker
);
    logic       a_q;
    logic       b_q;
    logic [7:0] gap_q;
    logic [7:0] gap_a_q;
    logic [7:0] mk_q;
    wire        ch_a = track_a ^ a_q;
    wire        ch_b = track_b ^ b_q;

    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= track_a;
            b_q <= track_b;
        end
    end

    // counters saturate so a long standstill never wraps into a false short gap
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) gap_q <= 8'hff;
        else if (ch_a || ch_b) gap_q <= 8'h00;
        else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) gap_a_q <= 8'hff;
        else if (ch_a) gap_a_q <= 8'h00;
        else if (gap_a_q != 8'hff) gap_a_q <= gap_a_q + 8'h01;
    end

    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) mk_q <= 8'h00;
        else if (!marker) mk_q <= 8'h00;
        else if (mk_q != 8'hff) mk_q <= mk_q + 8'h01;
    end

    one_track_a: assert property (!(ch_a && ch_b))
        else $error("both tracks changed together");
    step_spacing_a: assert property ((ch_a || ch_b) |-> gap_q >= 8'd24)
        else $error("track edges closer than one quarter step");
    half_period_a: assert property (ch_a |-> gap_a_q >= 8'd49)
        else $error("track a edges closer than half a period");
    marker_home_a: assert property (marker |-> !track_a && !track_b)
        else $error("marker outside home phase");
    marker_width_a: assert property ($fell(marker) |-> mk_q >= 8'd25)
        else $error("marker shorter than one quarter step");
    marker_edge_a: assert property ($fell(marker) |-> ch_a || ch_b)
        else $error("marker dropped without motion");

    cover property ($rose(marker));
    cover property (ch_a);
    cover property (ch_b);
endmodule

`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
    import quad_pkg::*;
();
    logic        clk;
    logic        rst;
    logic        run;
    logic        dir;
    logic        single;
    logic        init;
    logic        init2;
    logic [1:0]  mode;
    logic [31:0] angle;
    logic [31:0] pos;
    logic [15:0] turns;
    logic        valid;
    logic        seek;
    logic        dirq;
    logic        err;
    logic        valid2;
    logic        err2;
    int          fail_count;
    int          num_checks;
    int          cyc;
    int          m;

    quad_if link();
    quad_if bad();

    quad_encoder u_quad_encoder (.REF_CLK_IN(clk), .RST_IN(rst), .RUN_IN(run), .DIR_IN(dir),
        .SINGLE_IN(single), .MARKER_EN_IN(1'b1), .ANGLE_OUT(angle), .link(link));
    quad_counter u_quad_counter (.REF_CLK_IN(clk), .RST_IN(rst), .MODE_IN(mode),
        .SINGLE_IN(single), .INIT_IN(init), .POSITION_OUT(pos), .TURNS_OUT(turns),
        .VALID_OUT(valid), .SEEKING_OUT(seek), .DIR_OUT(dirq), .ERROR_OUT(err), .link(link));
    // second counter faces a hand-driven link that breaks the quadrature order
    quad_counter u_quad_counter_2 (.REF_CLK_IN(clk), .RST_IN(rst), .MODE_IN(mode),
        .SINGLE_IN(1'b0), .INIT_IN(init2), .POSITION_OUT(), .TURNS_OUT(), .VALID_OUT(valid2),
        .SEEKING_OUT(), .DIR_OUT(), .ERROR_OUT(err2), .link(bad));
    quad_properties u_quad_properties (.REF_CLK_IN(clk), .RST_IN(rst),
        .track_a(link.track_a), .track_b(link.track_b), .marker(link.marker));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // long settle after each move keeps the marker and track spacing legal
    task automatic move(input logic d, input int n);
        logic [31:0] w;
        dir <= d;
        run <= 1'b1;
        for (int k = 0; k < n; k++) begin
            w = angle;
            for (int t = 0; t < 60 && angle === w; t++) @(posedge clk);
        end
        run <= 1'b0;
        repeat (25) @(posedge clk);
    endtask

    task automatic pulse_init();
        init <= 1'b1;
        @(posedge clk);
        init <= 1'b0;
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        rst = 1'b1;
        run = 1'b0;
        dir = 1'b0;
        init = 1'b0;
        init2 = 1'b0;
        single = 1'b0;
        mode = MODE_X4;
        bad.track_a = 1'b0;
        bad.track_b = 1'b0;
        bad.marker = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (30) @(posedge clk);
        chk("dir", 1, dirq);
        move(1'b0, 4);
        chk("valid", 0, valid);
        chk("pos", 0, pos);
        chk("angle", 4, angle);
        for (m = 0; m < 3; m++) begin
            mode <= m[1:0];
            pulse_init();
            chk("seek", 1, seek);
            move(1'b1, 4);
            chk("valid", 1, valid);
            chk("seek", 0, seek);
            chk("pos", 0, pos);
            move(1'b0, 8);
            chk("pos", 32'(2 << m), pos);
            chk("dir", 1, dirq);
            move(1'b1, 4);
            chk("pos", 32'(1 << m), pos);
            chk("dir", 0, dirq);
        end
        move(1'b1, 5);
        chk("pos", 32'hfff, pos);
        chk("turns", 32'hffff, {16'h0000, turns});
        chk("err", 0, err);
        // single track: b held low, so every counted a rise is taken as forward
        single <= 1'b1;
        mode <= MODE_X1;
        pulse_init();
        move(1'b0, 1);
        chk("marker", 1, link.marker);
        chk("valid", 1, valid);
        move(1'b0, 8);
        move(1'b1, 4);
        chk("pos", 3, pos);
        chk("dir", 1, dirq);
        chk("track_b", 0, link.track_b);
        init2 <= 1'b1;
        @(posedge clk);
        init2 <= 1'b0;
        bad.marker <= 1'b1;
        repeat (6) @(posedge clk);
        chk("valid2", 1, valid2);
        bad.marker <= 1'b0;
        bad.track_a <= 1'b1;
        bad.track_b <= 1'b1;
        repeat (6) @(posedge clk);
        chk("err2", 1, err2);
        chk("valid2", 0, valid2);
        init2 <= 1'b1;
        @(posedge clk);
        init2 <= 1'b0;
        @(posedge clk);
        chk("err2", 0, err2);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("valid", 0, valid);
        chk("err", 0, err);
        chk("dir", 1, dirq);
        move(1'b0, 1);
        chk("valid", 0, valid);
        chk("pos", 0, pos);
        results();
    end
endmodule

`default_nettype wire
